// *** design/cis_pkg.sv ***
// Shared constants, types and helper functions of the interrupt sequencer
package cis_pkg;

  // Data widths
  localparam int FLAG_W = 16; // Flag word width
  localparam int PC_W = 24; // Program counter width
  localparam int LVL_W = 3; // Priority level width
  localparam int TRAP_W = 7; // Software trap number width

  // Interrupt information read addresses
  localparam logic [31:0] INFO_ADDR = 32'h0000_0000; // Normal entry
  localparam logic [31:0] INFO_ADDR_FAST = 32'h0000_0002; // Fast entry

  // Flag word field positions and reset value
  localparam int FLG_D_BIT = 1; // Debug flag
  localparam int FLG_I_BIT = 6; // Global interrupt enable
  localparam int FLG_U_BIT = 7; // Stack select flag
  localparam int FLG_IPL_LSB = 12; // Priority level field
  localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;

  // Levels forced for sources without programmable level
  localparam logic [LVL_W-1:0] IPL_TOP = 3'h7;
  localparam logic [LVL_W-1:0] IPL_ON_RESET = 3'h0;

  // Trap numbers that leave the stack select flag alone
  localparam logic [TRAP_W-1:0] TRAP_USTAY_LO = 7'h20;
  localparam logic [TRAP_W-1:0] TRAP_USTAY_HI = 7'h3F;

  // Entry lengths in cycles
  localparam logic [4:0] CYC_PERIPH_16 = 5'h0E;
  localparam logic [4:0] CYC_PERIPH_8 = 5'h10;
  localparam logic [4:0] CYC_TRAP_16 = 5'h0C;
  localparam logic [4:0] CYC_TRAP_8 = 5'h0E;
  localparam logic [4:0] CYC_FIXED_16 = 5'h0D;
  localparam logic [4:0] CYC_FIXED_8 = 5'h0F;
  localparam logic [4:0] CYC_OVF_16 = 5'h0E;
  localparam logic [4:0] CYC_OVF_8 = 5'h10;
  localparam logic [4:0] CYC_BRKR_16 = 5'h11;
  localparam logic [4:0] CYC_BRKR_8 = 5'h13;
  localparam logic [4:0] CYC_DEBUG_16 = 5'h13;
  localparam logic [4:0] CYC_DEBUG_8 = 5'h15;
  localparam logic [4:0] CYC_FAST = 5'h05;

  // Step numbers inside an entry
  localparam logic [4:0] STEP_INFO = 5'h00;
  localparam logic [4:0] STEP_TEMP = 5'h01;
  localparam logic [4:0] STEP_CLEAR = 5'h02;
  localparam logic [4:0] STEP_SAVE_FLAG = 5'h03;
  localparam logic [4:0] STEP_PC_HI = 5'h04;
  localparam logic [4:0] STEP_PC_LO = 5'h05;

  // Extended divide worst-case delays
  localparam logic [6:0] EXTENDED_DIVIDE_OP_MAX = 7'h1D; // Immediate or register divisor
  localparam logic [6:0] DIV_NORM = 7'h02;
  localparam logic [6:0] DIV_INDEX = 7'h03;
  localparam logic [6:0] DIV_IND = 7'h05;
  localparam logic [6:0] DIV_IND_INDEX = 7'h06;

  // Entry kinds
  typedef enum logic [2:0] {
    kind_periph, kind_trap, kind_fixed, kind_overflow,
    kind_brk_reloc, kind_debug, kind_fast
  } cis_kind_t;

  // Winning hardware source
  typedef enum logic [2:0] {
    src_none, src_reset, src_nmi, src_wdt, src_periph, src_step, src_addr
  } cis_src_t;

  // Sequencer states
  typedef enum logic {st_idle, st_entry} cis_state_t;

  // Entry length for a kind, bus width and vector alignment
  function automatic logic [4:0] entry_cycles(cis_kind_t k, logic bus8, logic odd);
    logic slow;
    slow = bus8 | odd;
    unique case (k)
      kind_periph: entry_cycles = slow ? CYC_PERIPH_8 : CYC_PERIPH_16;
      kind_trap: entry_cycles = slow ? CYC_TRAP_8 : CYC_TRAP_16;
      kind_fixed: entry_cycles = bus8 ? CYC_FIXED_8 : CYC_FIXED_16;
      kind_overflow: entry_cycles = bus8 ? CYC_OVF_8 : CYC_OVF_16;
      kind_brk_reloc: entry_cycles = slow ? CYC_BRKR_8 : CYC_BRKR_16;
      kind_debug: entry_cycles = bus8 ? CYC_DEBUG_8 : CYC_DEBUG_16;
      default: entry_cycles = CYC_FAST;
    endcase
  endfunction

  // Worst delay of an extended divide before entry may start
  function automatic logic [6:0] divide_delay(logic [1:0] mode, logic [3:0] x,
                                              logic [3:0] y, logic slow);
    logic [6:0] xw;
    logic [6:0] yw;
    xw = slow ? {2'h0, x, 1'b0} : {3'h0, x};
    yw = slow ? {2'h0, y, 1'b0} : {3'h0, y};
    unique case (mode)
      2'h0: divide_delay = EXTENDED_DIVIDE_OP_MAX + DIV_NORM + xw;
      2'h1: divide_delay = EXTENDED_DIVIDE_OP_MAX + DIV_INDEX + xw;
      2'h2: divide_delay = EXTENDED_DIVIDE_OP_MAX + DIV_IND + xw + {yw[5:0], 1'b0};
      default: divide_delay = EXTENDED_DIVIDE_OP_MAX + DIV_IND_INDEX + xw + {yw[5:0], 1'b0};
    endcase
  endfunction

endpackage

// *** design/cis_arbiter.sv ***
// Priority resolution of hardware interrupt requests
module cis_arbiter #(
  parameter int NUM_PERIPH = 8,
  parameter int IDX_W = $clog2(NUM_PERIPH)
) (
  // Fixed-order sources
  input wire logic reset_req,
  input wire logic nmi_req,
  input wire logic wdt_req,
  input wire logic step_req,
  input wire logic addr_match_req,
  // Maskable peripheral sources
  input wire logic [NUM_PERIPH-1:0] pending_request_bit,
  input wire logic [NUM_PERIPH*cis_pkg::LVL_W-1:0] periph_level,
  // Masking state
  input wire logic i_flag,
  input wire logic [cis_pkg::LVL_W-1:0] processor_priority_level,
  // Winner
  output logic win_valid,
  output cis_pkg::cis_src_t win_src,
  output logic [IDX_W-1:0] win_idx,
  output logic [cis_pkg::LVL_W-1:0] win_lvl
);

  logic per_found; // Some peripheral is eligible
  logic [cis_pkg::LVL_W-1:0] lvl_i; // Level under test

  // Highest eligible level, lowest index on a tie
  always_comb begin
    per_found = 1'b0;
    win_idx = '0;
    win_lvl = '0;
    lvl_i = '0;
    for (int i = 0; i < NUM_PERIPH; i++) begin
      lvl_i = periph_level[i*cis_pkg::LVL_W +: cis_pkg::LVL_W];
      // Enable, pending and strictly above the current level
      if (i_flag && pending_request_bit[i] && lvl_i > processor_priority_level) begin
        if (!per_found || lvl_i > win_lvl) begin
          per_found = 1'b1;
          win_idx = IDX_W'(i);
          win_lvl = lvl_i;
        end
      end
    end
  end

  // Fixed hardware order between source classes
  always_comb begin
    win_valid = 1'b1;
    if (reset_req) win_src = cis_pkg::src_reset;
    else if (nmi_req) win_src = cis_pkg::src_nmi;
    else if (wdt_req) win_src = cis_pkg::src_wdt;
    else if (per_found) win_src = cis_pkg::src_periph;
    else if (step_req) win_src = cis_pkg::src_step;
    else if (addr_match_req) win_src = cis_pkg::src_addr;
    else begin
      win_src = cis_pkg::src_none;
      win_valid = 1'b0;
    end
  end

endmodule

// *** design/cis_sequencer.sv ***
// Interrupt entry and exit sequencer of the CPU core
module cis_sequencer #(
  parameter int NUM_PERIPH = 8,
  parameter int IDX_W = $clog2(NUM_PERIPH)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Hardware requests
  input wire logic reset_req,
  input wire logic nmi_req,
  input wire logic wdt_req,
  input wire logic step_req,
  input wire logic addr_match_req,
  input wire logic [NUM_PERIPH-1:0] pending_request_bit,
  input wire logic [NUM_PERIPH*cis_pkg::LVL_W-1:0] periph_level,
  input wire logic fast_en,
  input wire logic [IDX_W-1:0] fast_idx,
  // Pipeline status
  input wire logic insn_done,
  input wire logic long_op_active,
  input wire logic [cis_pkg::PC_W-1:0] pc_in,
  input wire logic flag_wr_en,
  input wire logic [cis_pkg::FLAG_W-1:0] flag_wr_data,
  // Software traps
  input wire logic trap_req,
  input wire cis_pkg::cis_kind_t trap_kind,
  input wire logic [cis_pkg::TRAP_W-1:0] trap_num,
  // Vector fetch conditions
  input wire logic bus_8bit,
  input wire logic vector_odd,
  input wire logic [cis_pkg::PC_W-1:0] vector_addr,
  // Returns
  input wire logic return_from_interrupt_op,
  input wire logic fast_return_op,
  input wire logic [cis_pkg::FLAG_W-1:0] stack_flag_in,
  input wire logic [cis_pkg::PC_W-1:0] stack_pc_in,
  // Extended divide bound
  input wire logic extended_divide_op,
  input wire logic [1:0] div_mode,
  input wire logic [3:0] div_wait_x,
  input wire logic [3:0] div_wait_y,
  input wire logic div_slow,
  // Entry side effects
  output logic suspend,
  output logic busy,
  output logic info_rd,
  output logic [31:0] info_addr,
  output logic ack_valid,
  output logic [IDX_W-1:0] ack_idx,
  output logic push_valid,
  output logic [15:0] push_data,
  output logic fast_bank,
  // Control transfer
  output logic jump_valid,
  output logic [cis_pkg::PC_W-1:0] jump_pc,
  // State
  output logic [cis_pkg::FLAG_W-1:0] cpu_flag_word,
  output logic [6:0] div_bound
);

  ////////////////////////////////////////////////////////////////////////
  // Arbitration
  logic win_valid; // Some hardware request eligible
  cis_pkg::cis_src_t win_src; // Winning class
  logic [IDX_W-1:0] win_idx; // Winning peripheral
  logic [cis_pkg::LVL_W-1:0] win_lvl; // Winning level
  logic [cis_pkg::LVL_W-1:0] ipl_cur; // Current priority level

  assign ipl_cur = cpu_flag_word[cis_pkg::FLG_IPL_LSB +: cis_pkg::LVL_W];

  // Same-cycle snapshot of all requests
  cis_arbiter #(.NUM_PERIPH(NUM_PERIPH), .IDX_W(IDX_W)) u_arb (
    .reset_req(reset_req),
    .nmi_req(nmi_req),
    .wdt_req(wdt_req),
    .step_req(step_req),
    .addr_match_req(addr_match_req),
    .pending_request_bit(pending_request_bit),
    .periph_level(periph_level),
    .i_flag(cpu_flag_word[cis_pkg::FLG_I_BIT]),
    .processor_priority_level(ipl_cur),
    .win_valid(win_valid),
    .win_src(win_src),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  cis_pkg::cis_state_t state_r, state_nxt; // Idle or entering
  logic [4:0] step_r, step_nxt; // Step within entry
  logic [4:0] len_r, len_nxt; // Entry length
  cis_pkg::cis_kind_t kind_r, kind_nxt; // Entry kind
  cis_pkg::cis_src_t src_r, src_nxt; // Source class
  logic [cis_pkg::LVL_W-1:0] lvl_r, lvl_nxt; // Accepted level
  logic [cis_pkg::TRAP_W-1:0] tnum_r, tnum_nxt; // Trap number
  logic bus8_r, bus8_nxt; // Bus width latched
  logic odd_r, odd_nxt; // Vector alignment latched
  logic [cis_pkg::FLAG_W-1:0] flag_r, flag_nxt; // Flag word
  logic [cis_pkg::FLAG_W-1:0] temp_r, temp_nxt; // Hidden temp copy
  logic [cis_pkg::PC_W-1:0] pc_r, pc_nxt; // Interrupted PC
  logic [cis_pkg::FLAG_W-1:0] flag_shadow_register, flag_sh_nxt;
  logic [cis_pkg::PC_W-1:0] pc_shadow_register, pc_sh_nxt;
  logic info_rd_r, info_rd_nxt; // Info read strobe
  logic [31:0] info_addr_r, info_addr_nxt; // Info read address
  logic ack_r, ack_nxt; // Pending bit clear strobe
  logic [IDX_W-1:0] ack_idx_r, ack_idx_nxt; // Pending bit to clear
  logic push_r, push_nxt; // Stack push strobe
  logic [15:0] push_data_r, push_data_nxt; // Stack push word
  logic fast_bank_r, fast_bank_nxt; // Fast handler active
  logic jump_r, jump_nxt; // Control transfer strobe
  logic [cis_pkg::PC_W-1:0] jump_pc_r, jump_pc_nxt; // Target address
  logic [6:0] div_bound_r, div_bound_nxt; // Divide delay bound
  logic hw_start; // Hardware entry begins
  logic is_fast; // Winner uses the fast path
  cis_pkg::cis_kind_t hw_kind; // Kind for hardware winner

  // Boundary or suspendable op; traps go without arbitration
  assign hw_start = win_valid && (insn_done || long_op_active) && !trap_req;
  assign is_fast = fast_en && win_src == cis_pkg::src_periph && win_idx == fast_idx;
  assign suspend = state_r == cis_pkg::st_idle && hw_start && long_op_active && !insn_done;
  assign busy = state_r == cis_pkg::st_entry;

  // Kind for the hardware winner
  always_comb begin
    unique case (win_src)
      cis_pkg::src_periph: hw_kind = is_fast ? cis_pkg::kind_fast : cis_pkg::kind_periph;
      cis_pkg::src_step: hw_kind = cis_pkg::kind_debug;
      default: hw_kind = cis_pkg::kind_fixed;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    len_nxt = len_r;
    kind_nxt = kind_r;
    src_nxt = src_r;
    lvl_nxt = lvl_r;
    tnum_nxt = tnum_r;
    bus8_nxt = bus8_r;
    odd_nxt = odd_r;
    flag_nxt = flag_r;
    temp_nxt = temp_r;
    pc_nxt = pc_r;
    flag_sh_nxt = flag_shadow_register;
    pc_sh_nxt = pc_shadow_register;
    info_rd_nxt = 1'b0;
    info_addr_nxt = info_addr_r;
    ack_nxt = 1'b0;
    ack_idx_nxt = ack_idx_r;
    push_nxt = 1'b0;
    push_data_nxt = push_data_r;
    fast_bank_nxt = fast_bank_r;
    jump_nxt = 1'b0;
    jump_pc_nxt = jump_pc_r;
    // Bound tracks the divide now running
    div_bound_nxt = extended_divide_op ?
      cis_pkg::divide_delay(div_mode, div_wait_x, div_wait_y, div_slow) : div_bound_r;
    unique case (state_r)
      cis_pkg::st_idle: begin
        // Pipeline writes of the flag word
        if (flag_wr_en) flag_nxt = flag_wr_data;
        if (return_from_interrupt_op) begin
          // Restore from stack words
          flag_nxt = stack_flag_in;
          jump_nxt = 1'b1;
          jump_pc_nxt = stack_pc_in;
        end else if (fast_return_op) begin
          // Restore from shadows, leave fast bank
          flag_nxt = flag_shadow_register;
          jump_nxt = 1'b1;
          jump_pc_nxt = pc_shadow_register;
          fast_bank_nxt = 1'b0;
        end else if (trap_req || hw_start) begin
          state_nxt = cis_pkg::st_entry;
          step_nxt = cis_pkg::STEP_INFO;
          kind_nxt = trap_req ? trap_kind : hw_kind;
          src_nxt = trap_req ? cis_pkg::src_none : win_src;
          lvl_nxt = win_lvl;
          tnum_nxt = trap_num;
          bus8_nxt = bus_8bit;
          odd_nxt = vector_odd;
          len_nxt = cis_pkg::entry_cycles(trap_req ? trap_kind : hw_kind,
                                          bus_8bit, vector_odd);
          pc_nxt = pc_in;
          // Info fetch and pending clear in step 0
          info_rd_nxt = 1'b1;
          info_addr_nxt = (!trap_req && is_fast) ? cis_pkg::INFO_ADDR_FAST : cis_pkg::INFO_ADDR;
          ack_nxt = !trap_req && win_src == cis_pkg::src_periph;
          ack_idx_nxt = win_idx;
        end
      end
      cis_pkg::st_entry: begin
        step_nxt = step_r + 5'h01;
        unique case (step_r)
          // Hidden copy of flag word before entry
          cis_pkg::STEP_TEMP: temp_nxt = flag_r;
          cis_pkg::STEP_CLEAR: begin
            flag_nxt[cis_pkg::FLG_I_BIT] = 1'b0;
            flag_nxt[cis_pkg::FLG_D_BIT] = 1'b0;
            // Stack select kept for traps 32 to 63
            if (!(kind_r == cis_pkg::kind_trap && tnum_r >= cis_pkg::TRAP_USTAY_LO &&
                  tnum_r <= cis_pkg::TRAP_USTAY_HI)) begin
              flag_nxt[cis_pkg::FLG_U_BIT] = 1'b0;
            end
          end
          cis_pkg::STEP_SAVE_FLAG: begin
            if (kind_r == cis_pkg::kind_fast) begin
              // Shadows instead of stack, bank one selected
              flag_sh_nxt = temp_r;
              pc_sh_nxt = pc_r;
              fast_bank_nxt = 1'b1;
            end else begin
              push_nxt = 1'b1;
              push_data_nxt = temp_r;
            end
          end
          cis_pkg::STEP_PC_HI: begin
            // Upper byte of PC widened to 16 bits
            push_nxt = kind_r != cis_pkg::kind_fast;
            push_data_nxt = {8'h00, pc_r[23:16]};
          end
          cis_pkg::STEP_PC_LO: begin
            push_nxt = kind_r != cis_pkg::kind_fast;
            push_data_nxt = pc_r[15:0];
          end
          default: begin
          end
        endcase
        // Last step: level update and jump
        if (step_r == len_r - 5'h01) begin
          state_nxt = cis_pkg::st_idle;
          jump_nxt = 1'b1;
          jump_pc_nxt = vector_addr;
          if (kind_r == cis_pkg::kind_periph || kind_r == cis_pkg::kind_fast) begin
            flag_nxt[cis_pkg::FLG_IPL_LSB +: cis_pkg::LVL_W] = lvl_r;
          end else if (src_r == cis_pkg::src_nmi || src_r == cis_pkg::src_wdt) begin
            flag_nxt[cis_pkg::FLG_IPL_LSB +: cis_pkg::LVL_W] = cis_pkg::IPL_TOP;
          end else if (src_r == cis_pkg::src_reset) begin
            flag_nxt[cis_pkg::FLG_IPL_LSB +: cis_pkg::LVL_W] = cis_pkg::IPL_ON_RESET;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= cis_pkg::st_idle;
      step_r <= '0;
      len_r <= cis_pkg::CYC_FAST;
      kind_r <= cis_pkg::kind_periph;
      src_r <= cis_pkg::src_none;
      lvl_r <= '0;
      tnum_r <= '0;
      bus8_r <= 1'b0;
      odd_r <= 1'b0;
      flag_r <= cis_pkg::FLAG_RESET;
      temp_r <= '0;
      pc_r <= '0;
      flag_shadow_register <= '0;
      pc_shadow_register <= '0;
      info_rd_r <= 1'b0;
      info_addr_r <= '0;
      ack_r <= 1'b0;
      ack_idx_r <= '0;
      push_r <= 1'b0;
      push_data_r <= '0;
      fast_bank_r <= 1'b0;
      jump_r <= 1'b0;
      jump_pc_r <= '0;
      div_bound_r <= cis_pkg::EXTENDED_DIVIDE_OP_MAX;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      len_r <= len_nxt;
      kind_r <= kind_nxt;
      src_r <= src_nxt;
      lvl_r <= lvl_nxt;
      tnum_r <= tnum_nxt;
      bus8_r <= bus8_nxt;
      odd_r <= odd_nxt;
      flag_r <= flag_nxt;
      temp_r <= temp_nxt;
      pc_r <= pc_nxt;
      flag_shadow_register <= flag_sh_nxt;
      pc_shadow_register <= pc_sh_nxt;
      info_rd_r <= info_rd_nxt;
      info_addr_r <= info_addr_nxt;
      ack_r <= ack_nxt;
      ack_idx_r <= ack_idx_nxt;
      push_r <= push_nxt;
      push_data_r <= push_data_nxt;
      fast_bank_r <= fast_bank_nxt;
      jump_r <= jump_nxt;
      jump_pc_r <= jump_pc_nxt;
      div_bound_r <= div_bound_nxt;
    end
  end

  // Registered outputs
  assign info_rd = info_rd_r;
  assign info_addr = info_addr_r;
  assign ack_valid = ack_r;
  assign ack_idx = ack_idx_r;
  assign push_valid = push_r;
  assign push_data = push_data_r;
  assign fast_bank = fast_bank_r;
  assign jump_valid = jump_r;
  assign jump_pc = jump_pc_r;
  assign cpu_flag_word = flag_r;
  assign div_bound = div_bound_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  boundary_entry_a: assert property (!busy && !trap_req && win_valid && insn_done &&
    !return_from_interrupt_op && !fast_return_op |=> busy && step_r == 5'h00 && info_rd)
    else $error("entry not started after boundary");
  suspend_entry_a: assert property (suspend && !return_from_interrupt_op && !fast_return_op
    |=> busy && info_rd) else $error("suspended op did not enter");
  info_clear_a: assert property (ack_valid |-> info_rd && busy && step_r == 5'h00 &&
    info_addr == (kind_r == cis_pkg::kind_fast ? cis_pkg::INFO_ADDR_FAST : cis_pkg::INFO_ADDR))
    else $error("pending clear without info read");
  temp_copy_a: assert property (busy && step_r == 5'h01 |=> temp_r == $past(flag_r))
    else $error("temp copy wrong");
  flag_clear_a: assert property (busy && step_r == 5'h02 |=> !flag_r[cis_pkg::FLG_I_BIT] &&
    !flag_r[cis_pkg::FLG_D_BIT]) else $error("flags not cleared");
  push_order_a: assert property (push_valid && step_r == 5'h04 |-> push_data == temp_r ##1
    push_valid && push_data == {8'h00, pc_r[23:16]} ##1 push_valid && push_data == pc_r[15:0])
    else $error("stack push order wrong");
  fast_shadow_a: assert property (busy && kind_r == cis_pkg::kind_fast && step_r == 5'h03
    |=> flag_shadow_register == temp_r && pc_shadow_register == pc_r && !push_valid)
    else $error("fast save wrong");
  entry_len_a: assert property (jump_valid && $past(busy) |->
    $past(step_r) == cis_pkg::entry_cycles(kind_r, bus8_r, odd_r) - 5'h01)
    else $error("entry length wrong");
  fast_len_a: assert property (busy && step_r == 5'h00 && kind_r == cis_pkg::kind_fast
    |-> ##4 jump_valid == 1'b0 ##1 jump_valid) else $error("fast entry not 5 cycles");
  ipl_load_a: assert property (jump_valid && $past(busy) && kind_r == cis_pkg::kind_periph
    |-> ipl_cur == lvl_r) else $error("level not loaded");
  ipl_fixed_a: assert property (jump_valid && $past(busy) && src_r == cis_pkg::src_nmi
    |-> ipl_cur == cis_pkg::IPL_TOP) else $error("NMI level not 7");
  mask_accept_a: assert property (win_src == cis_pkg::src_periph |->
    cpu_flag_word[cis_pkg::FLG_I_BIT] && win_lvl > ipl_cur)
    else $error("masked request won");
  return_a: assert property (!busy && return_from_interrupt_op |=> jump_valid &&
    jump_pc == $past(stack_pc_in) && cpu_flag_word == $past(stack_flag_in))
    else $error("return restore wrong");

endmodule

// *** test/cis_src_model.sv ***
// Peripheral request source model holding pending bits until acknowledged
module cis_src_model #(
  parameter int NUM_PERIPH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Request triggers and acknowledge from the sequencer
  input wire logic [NUM_PERIPH-1:0] fire,
  input wire logic ack_valid,
  input wire logic [2:0] ack_idx,
  // Pending bits seen by the sequencer
  output logic [NUM_PERIPH-1:0] pend
);
  timeunit 1ns;
  timeprecision 1ps;
  // Set on trigger, cleared only by the acknowledge pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= '0;
    end else begin
      pend <= (pend | fire) & ~(ack_valid ? NUM_PERIPH'(1) << ack_idx : '0);
    end
  end
endmodule

// *** test/tb.sv ***
// Testbench of the interrupt sequencer with queue scoreboard
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, nmi_req, fast_en, insn_done, long_op_active, flag_wr_en, trap_req;
  logic bus_8bit, vector_odd, return_from_interrupt_op, fast_return_op, div_slow;
  logic busy, info_rd, ack_valid, push_valid, jump_valid, fast_bank, suspend, ext_div;
  logic [7:0] pend, fire;
  logic [2:0] fast_idx, ack_idx;
  logic [23:0] pc_in, vector_addr, stack_pc_in, jump_pc, last_pc;
  logic [15:0] flag_wr_data, stack_flag_in, push_data, cpu_flag_word;
  logic [6:0] trap_num, div_bound;
  logic [1:0] div_mode;
  logic [3:0] div_wait_x, div_wait_y;
  logic [31:0] info_addr;
  logic [4:0] cyc = '0;
  logic sus_r = 1'b0; // Suspend seen on the accept edge
  logic [63:0] pq[$], iq[$], jq[$];
  cis_pkg::cis_kind_t trap_kind;
  int bad_count = 0, n_checks = 0, seed = 9035;
  int xw, yw, dexp; // Divide bound expectation
  cis_sequencer u_cis_sequencer (.clk(clk), .arst_n(arst_n), .reset_req(1'b0), .nmi_req(nmi_req),
    .wdt_req(1'b0), .step_req(1'b0), .addr_match_req(1'b0), .pending_request_bit(pend),
    .periph_level(24'h000568), .fast_en(fast_en), .fast_idx(fast_idx), .insn_done(insn_done),
    .long_op_active(long_op_active), .pc_in(pc_in), .flag_wr_en(flag_wr_en),
    .flag_wr_data(flag_wr_data), .trap_req(trap_req), .trap_kind(trap_kind),
    .trap_num(trap_num), .bus_8bit(bus_8bit), .vector_odd(vector_odd),
    .vector_addr(vector_addr), .return_from_interrupt_op(return_from_interrupt_op),
    .fast_return_op(fast_return_op), .stack_flag_in(stack_flag_in), .stack_pc_in(stack_pc_in),
    .extended_divide_op(ext_div), .div_mode(div_mode), .div_wait_x(div_wait_x),
    .div_wait_y(div_wait_y), .div_slow(div_slow), .suspend(suspend), .busy(busy),
    .info_rd(info_rd), .info_addr(info_addr), .ack_valid(ack_valid), .ack_idx(ack_idx),
    .push_valid(push_valid), .push_data(push_data), .fast_bank(fast_bank),
    .jump_valid(jump_valid), .jump_pc(jump_pc), .cpu_flag_word(cpu_flag_word),
    .div_bound(div_bound));
  cis_src_model u_cis_src_model (.clk(clk), .arst_n(arst_n), .fire(fire),
    .ack_valid(ack_valid), .ack_idx(ack_idx), .pend(pend));
  // Single compare of any result against its note
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Stack push against its oldest note
  task chk_push(input logic [15:0] g);
    chk(64'(g), pq.pop_front());
  endtask
  // Info read and suspend flag against its oldest note
  task chk_info(input logic [32:0] g);
    chk(64'(g), iq.pop_front());
  endtask
  // Jump, flag word, bank and length against its oldest note
  task chk_jump(input logic [63:0] g);
    chk(g, jq.pop_front());
  endtask
  // Verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Entry: how 0 ends an instruction, 1 suspends a long op, 2 runs a trap
  task ent(input logic [4:0] len, input logic [15:0] fi, fo, input logic fast, input int how);
    logic [31:0] r;
    r = $random(seed);
    last_pc = r[23:0];
    pc_in <= r[23:0];
    iq.push_back({31'h0, how == 1, 30'h0, fast, 1'b0});
    if (!fast) pq = {pq, 64'(fi), 64'(r[23:16]), 64'(r[15:0])};
    jq.push_back({15'h0, fast, fo, vector_addr, 3'h0, len});
    {trap_req, long_op_active, insn_done} <= 3'(1 << how);
    @(posedge clk);
    {trap_req, long_op_active, insn_done} <= 3'h0;
    @(posedge clk iff jump_valid === 1'b1);
  endtask
  // Return from stack, or from shadows with a decoy on the stack PC input
  task ret(input logic fast);
    logic [31:0] r;
    r = $random(seed);
    if (!fast) last_pc = r[23:0];
    stack_flag_in <= 16'h00C0;
    stack_pc_in <= fast ? ~last_pc : last_pc;
    jq.push_back({16'h0, 16'h00C0, last_pc, 8'h00});
    {fast_return_op, return_from_interrupt_op} <= {fast, !fast};
    @(posedge clk);
    {fast_return_op, return_from_interrupt_op} <= 2'h0;
    @(posedge clk iff jump_valid === 1'b1);
  endtask
  task fire_req(input logic [7:0] m);
    fire <= m;
    @(posedge clk);
    fire <= 8'h00;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Result watcher taking the oldest note of each kind
  always @(posedge clk) begin
    if (push_valid === 1'b1) chk_push(push_data);
    if (info_rd === 1'b1) chk_info({sus_r, info_addr});
    if (jump_valid === 1'b1)
      chk_jump({15'h0, fast_bank, cpu_flag_word, jump_pc, 3'h0, cyc});
    cyc <= busy ? cyc + 5'h1 : 5'h0;
    sus_r <= suspend;
  end
  // Watchdog
  initial begin
    repeat (1000) @(posedge clk);
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    {nmi_req, fast_en, insn_done, long_op_active, flag_wr_en, trap_req, bus_8bit} = '0;
    {vector_odd, return_from_interrupt_op, fast_return_op, fire, arst_n, ext_div} = '0;
    {div_mode, div_wait_x, div_wait_y, div_slow} = 11'($random(seed));
    {pc_in, stack_pc_in, flag_wr_data, stack_flag_in} = '0;
    {fast_idx, trap_num} = {3'h3, 7'h21};
    trap_kind = cis_pkg::kind_trap;
    vector_addr = 24'h01A4C6;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    {flag_wr_en, flag_wr_data} <= {1'b1, 16'h00C0};
    @(posedge clk);
    flag_wr_en <= 1'b0;
    fire_req(8'h04);
    ent(5'h0E, 16'h00C0, 16'h5000, 1'b0, 0);
    ret(1'b0);
    bus_8bit <= 1'b1;
    fire_req(8'h02);
    ent(5'h10, 16'h00C0, 16'h5000, 1'b0, 1);
    ret(1'b0);
    fast_en <= 1'b1;
    fire_req(8'h08);
    ent(5'h05, 16'h00C0, 16'h2000, 1'b1, 0);
    ret(1'b1);
    {fast_en, nmi_req, vector_odd, bus_8bit} <= 4'h6;
    ent(5'h0D, 16'h00C0, 16'h7000, 1'b0, 0);
    nmi_req <= 1'b0;
    ret(1'b0);
    bus_8bit <= 1'b1;
    ent(5'h0E, 16'h00C0, 16'h0080, 1'b0, 2);
    {bus_8bit, vector_odd} <= 2'h0;
    trap_kind <= cis_pkg::kind_brk_reloc;
    ent(5'h11, 16'h0080, 16'h0000, 1'b0, 2);
    // Divide bound: 29 plus memory divisor extras, waits doubled when slow
    xw = int'(div_wait_x) << div_slow;
    yw = int'(div_wait_y) << div_slow;
    dexp = 29 + xw + (div_mode < 2'h2 ? 2 + div_mode : 3 + div_mode + 2 * yw);
    ext_div <= 1'b1;
    @(posedge clk);
    ext_div <= 1'b0;
    @(posedge clk);
    chk(64'(div_bound), 64'(dexp));
    chk(64'(pq.size() + iq.size() + jq.size()), 64'h0);
    end_sim();
  end
endmodule
